// File: core/watchdog_timer_unit.sv
`timescale 1ns/1ps
// Contract
// - mode 00 keeps the watchdog disabled regardless of enable bit and Sleep.
// - mode 11 counts always, including Sleep; enable bit ignored.
// - mode 10 counts awake, disabled in Sleep; enable bit ignored.
// - mode 01 lets the software enable bit turn the watchdog on or off.
// - in mode 01 Sleep entry or exit does not change on/off.
// - period code sets ratio 1:32 shifted left by code, up to 10010.
// - period codes 10011 to 11111 behave like ratio 1:32.
// - any reset loads period code 01011, ratio 1:65536, about 2 s.
// - count cleared by reset, clear instruction and oscillator failure.
// - count held cleared whenever the watchdog is disabled.
// - entering Sleep clears count; if still enabled it counts from zero.
// - leaving Sleep clears count; stays clear until start-up timer finishes.
// - count held cleared while the oscillator start-up timer runs.
// - internal oscillator divider changes leave the count unaffected.
// - time-out in Sleep wakes, no reset, and updates status flags.
// - timebase is the 31 kHz low-frequency oscillator, intervals approximate.
// - control: enable bit 0 reset 0, period bits 5-1, bits 7-6 read 0.
// - time-out while awake generates a device reset.
// - intervals derive from a 32240 ns base, 1612 clocks approximating one 32258 ns period of the low-frequency oscillator.
module watchdog_timer_unit
  import watchdog_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // axi4-lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // configuration and device state
  input wire logic [1:0] watchdog_mode_cfg_i,
  input wire logic sleep_i,
  input wire logic clear_watchdog_instr_i,
  input wire logic osc_fail_i,
  input wire logic osc_startup_timer_i,
  // events and flags
  output logic watchdog_reset_o,
  output logic wake_o,
  output logic watchdog_active_o,
  output logic timeout_flag_o,
  output logic powerdown_flag_o,
  output logic watchdog_reset_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [1:0] mode_meta_q;
  logic [1:0] mode_q;
  logic sleep_q;
  logic enable;
  logic clear_cnt;
  logic sleep_enter;
  logic sleep_exit;
  logic tick;
  logic timeout;
  logic [COUNT_W-1:0] count;

  logic aw_hold_q, aw_hold_d;
  logic w_hold_q, w_hold_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic arready_q, arready_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic do_write;

  logic swen_q, swen_d;
  logic [PS_W-1:0] ps_q, ps_d;
  logic [STATUS_W-1:0] status_q, status_d;
  logic [STATUS_W-1:0] status_set;
  logic [STATUS_W-1:0] status_clr;
  logic wd_reset_q, wd_reset_d;
  logic wake_q, wake_d;
  logic active_q;

  ////////////////////////////////////////////////////////////////////////////
  // mode synchroniser, sleep edges, enable and clear

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_meta_q <= MODE_OFF;
      mode_q <= MODE_OFF;
      sleep_q <= 1'b0;
    end else begin
      mode_meta_q <= watchdog_mode_cfg_i;
      mode_q <= mode_meta_q;
      sleep_q <= sleep_i;
    end
  end

  assign sleep_enter = sleep_i & ~sleep_q;
  assign sleep_exit = ~sleep_i & sleep_q;

  always_comb begin
    case (mode_q)
      MODE_ALWAYS: enable = 1'b1;
      MODE_NO_SLEEP: enable = ~sleep_i;
      MODE_SOFT: enable = swen_q;
      default: enable = 1'b0;
    endcase
    clear_cnt = ~enable | clear_watchdog_instr_i | osc_fail_i | sleep_enter | sleep_exit
                | osc_startup_timer_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // timebase and prescaler

  // own divider, internal oscillator divider not used
  lf_tick_gen u_tick (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_o(tick)
  );

  watchdog_prescaler u_prescaler (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .tick_i(tick),
    .clear_i(clear_cnt),
    .period_select_i(ps_q),
    .count_o(count),
    .timeout_o(timeout)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  always_comb begin
    aw_hold_d = aw_hold_q;
    w_hold_d = w_hold_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    do_write = aw_hold_q & w_hold_q & ~bvalid_q;
    if (s_axi_awvalid_i && awready_q) begin
      aw_hold_d = 1'b1;
      awaddr_d = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && wready_q) begin
      w_hold_d = 1'b1;
      wdata_d = s_axi_wdata_i;
      wstrb_d = s_axi_wstrb_i;
    end
    if (bvalid_q && s_axi_bready_i) begin
      bvalid_d = 1'b0;
    end
    if (do_write) begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      if (awaddr_q == CTRL_OFFSET || awaddr_q == STATUS_OFFSET
          || awaddr_q == COUNT_OFFSET) begin
        bresp_d = RESP_OKAY;
      end else begin
        bresp_d = RESP_SLVERR;
      end
    end
    awready_d = ~aw_hold_d & ~bvalid_d;
    wready_d = ~w_hold_d & ~bvalid_d;
    if (s_axi_arvalid_i && arready_q) begin
      arready_d = 1'b0;
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      if (s_axi_araddr_i == CTRL_OFFSET) begin
        rdata_d = {26'h0000000, ps_q, swen_q};
      end else if (s_axi_araddr_i == STATUS_OFFSET) begin
        rdata_d = {29'h00000000, status_q};
      end else if (s_axi_araddr_i == COUNT_OFFSET) begin
        rdata_d = {9'h000, count};
      end else begin
        rdata_d = 32'h00000000;
        rresp_d = RESP_SLVERR;
      end
    end else if (rvalid_q && s_axi_rready_i) begin
      rvalid_d = 1'b0;
      arready_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, status and time-out events

  always_comb begin
    swen_d = swen_q;
    ps_d = ps_q;
    status_set = '0;
    status_clr = '0;
    if (do_write && wstrb_q[0] && awaddr_q == CTRL_OFFSET) begin
      swen_d = wdata_q[SWEN_BIT];
      ps_d = wdata_q[PS_MSB:PS_LSB];
    end
    if (do_write && wstrb_q[0] && awaddr_q == STATUS_OFFSET) begin
      status_clr = wdata_q[STATUS_W-1:0];
    end
    // a watchdog reset is a reset too
    if (wd_reset_q) begin
      swen_d = SWEN_RESET;
      ps_d = PS_RESET;
    end
    wd_reset_d = timeout & ~sleep_i;
    wake_d = timeout & sleep_i;
    status_set[ST_TIMEOUT_BIT] = timeout;
    status_set[ST_POWERDOWN_BIT] = timeout & sleep_i;
    status_set[ST_WDRESET_BIT] = timeout & ~sleep_i;
    // set wins over a clear in the same cycle
    status_d = (status_q & ~status_clr) | status_set;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      swen_q <= SWEN_RESET;
      ps_q <= PS_RESET;
      status_q <= '0;
      wd_reset_q <= 1'b0;
      wake_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      swen_q <= swen_d;
      ps_q <= ps_d;
      status_q <= status_d;
      wd_reset_q <= wd_reset_d;
      wake_q <= wake_d;
      active_q <= enable;
    end
  end

  assign s_axi_awready_o = awready_q;
  assign s_axi_wready_o = wready_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_arready_o = arready_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rdata_o = rdata_q;
  assign s_axi_rresp_o = rresp_q;
  assign watchdog_reset_o = wd_reset_q;
  assign wake_o = wake_q;
  assign watchdog_active_o = active_q;
  assign timeout_flag_o = status_q[ST_TIMEOUT_BIT];
  assign powerdown_flag_o = status_q[ST_POWERDOWN_BIT];
  assign watchdog_reset_flag_o = status_q[ST_WDRESET_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  a_mode_off_idle: assert property (
    (mode_q == MODE_OFF) [*2] |-> (count == 23'h000000 && !timeout))
    else $error("count moved in off mode");

  a_mode_always_on: assert property (
    (mode_q == MODE_ALWAYS) |-> enable)
    else $error("always-on mode disabled");

  a_mode_nosleep: assert property (
    (mode_q == MODE_NO_SLEEP && sleep_i) |=> (count == 23'h000000))
    else $error("count ran in sleep under mode 10");

  a_soft_enable: assert property (
    (mode_q == MODE_SOFT) |-> (enable == swen_q))
    else $error("soft mode ignores enable bit");

  a_clear_instr: assert property (
    (clear_watchdog_instr_i || osc_fail_i) |=> (count == 23'h000000))
    else $error("count not cleared");

  a_sleep_edges: assert property (
    ($rose(sleep_i) || $fell(sleep_i)) |=> (count == 23'h000000))
    else $error("count not cleared at sleep edge");

  a_startup_hold: assert property (
    osc_startup_timer_i |=> (count == 23'h000000))
    else $error("count ran during start-up timer");

  a_awake_reset: assert property (
    (timeout && !sleep_i) |=> (watchdog_reset_o && !wake_o && watchdog_reset_flag_o))
    else $error("awake time-out did not reset");

  a_sleep_wake: assert property (
    (timeout && sleep_i) |=> (wake_o && !watchdog_reset_o && powerdown_flag_o
                              && timeout_flag_o))
    else $error("sleep time-out misbehaved");

  a_period_reload: assert property (
    watchdog_reset_o |=> (ps_q == 5'h0B && !swen_q))
    else $error("period not reloaded after watchdog reset");

endmodule

// File: shared/watchdog_pkg.sv
package watchdog_pkg;

  // clock and low-frequency timebase
  localparam int CLK_PERIOD_NS = 20;
  localparam int LF_OSC_HZ = 31000;
  localparam int LF_PERIOD_NS = 32258;
  localparam int LF_DIV_CYCLES = LF_PERIOD_NS / CLK_PERIOD_NS;
  localparam int LF_DIV_W = 11;

  // watchdog mode encodings
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SOFT = 2'h1;
  localparam logic [1:0] MODE_NO_SLEEP = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;

  // prescaler
  localparam int COUNT_W = 23;
  localparam int PS_W = 5;
  localparam logic [PS_W-1:0] PS_RESET = 5'h0B;
  localparam logic [PS_W-1:0] PS_MAX_CODE = 5'h12;
  localparam logic [23:0] BASE_RATIO = 24'h000020;
  localparam logic [COUNT_W-1:0] MIN_LIMIT = 23'h00001F;

  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] COUNT_OFFSET = 8'h08;

  // control fields
  localparam int SWEN_BIT = 0;
  localparam int PS_LSB = 1;
  localparam int PS_MSB = 5;
  localparam logic SWEN_RESET = 1'b0;

  // status fields
  localparam int ST_TIMEOUT_BIT = 0;
  localparam int ST_POWERDOWN_BIT = 1;
  localparam int ST_WDRESET_BIT = 2;
  localparam int STATUS_W = 3;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// File: core/lf_tick_gen.sv
`timescale 1ns/1ps
module lf_tick_gen
  import watchdog_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // tick
  output logic tick_o
);

  logic [LF_DIV_W-1:0] div_q;
  logic [LF_DIV_W-1:0] div_d;
  logic tick_q;
  logic tick_d;

  always_comb begin
    div_d = div_q + 11'h001;
    tick_d = 1'b0;
    if (div_q == LF_DIV_W'(LF_DIV_CYCLES - 1)) begin
      div_d = 11'h000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_q <= 11'h000;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule

// File: core/watchdog_prescaler.sv
`timescale 1ns/1ps
module watchdog_prescaler
  import watchdog_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic [PS_W-1:0] period_select_i,
  // state
  output logic [COUNT_W-1:0] count_o,
  output logic timeout_o
);

  logic [COUNT_W-1:0] count_q;
  logic [COUNT_W-1:0] count_d;
  logic timeout_q;
  logic timeout_d;
  logic [COUNT_W-1:0] limit;

  always_comb begin
    if (period_select_i > PS_MAX_CODE) begin
      limit = MIN_LIMIT;
    end else begin
      limit = COUNT_W'((BASE_RATIO << period_select_i) - 24'h000001);
    end
    count_d = count_q;
    timeout_d = 1'b0;
    if (clear_i) begin
      count_d = '0;
    end else if (tick_i) begin
      if (count_q == limit) begin
        count_d = '0;
        timeout_d = 1'b1;
      end else begin
        count_d = count_q + 23'h000001;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_q <= '0;
      timeout_q <= 1'b0;
    end else begin
      count_q <= count_d;
      timeout_q <= timeout_d;
    end
  end

  assign count_o = count_q;
  assign timeout_o = timeout_q;

  a_limit_reserved: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (period_select_i > PS_MAX_CODE) |-> (limit == 23'h00001F))
    else $error("reserved period code not at minimum ratio");

  a_timeout_at_limit: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    timeout_q |-> ($past(count_q) == $past(limit) && count_q == 23'h000000))
    else $error("time-out not at selected ratio");

endmodule

// File: verif/watchdog_timer_unit_tb.sv
`timescale 1ns/1ps
module watchdog_timer_unit_tb;
  import watchdog_pkg::*;
  localparam int lf = LF_DIV_CYCLES;
  logic ref_clk_i;
  logic sys_rst_i;
  logic [ADDR_W-1:0] aw_a, ar_a;
  logic [31:0] wd, rdata, rd;
  logic [3:0] ws;
  logic aw_v, w_v, b_r, ar_v, r_r, aw_rdy, w_rdy, b_v, ar_rdy, r_v;
  logic [1:0] bresp, rresp, rs, mode;
  logic slp, clr, ofail, st_run, wd_rst, wake, act, tmo_f, pdn_f, wr_f;
  logic [31:0] rnd_d;
  logic [3:0] rnd_s;
  int fails = 0;
  int n_compared = 0;
  int seed = 44;
  int ctrl_m, cyc, rst_seen;

  watchdog_timer_unit uut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .s_axi_awaddr_i(aw_a), .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy),
    .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
    .s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(r_v),
    .s_axi_rready_i(r_r), .watchdog_mode_cfg_i(mode), .sleep_i(slp),
    .clear_watchdog_instr_i(clr), .osc_fail_i(ofail), .osc_startup_timer_i(st_run),
    .watchdog_reset_o(wd_rst), .wake_o(wake), .watchdog_active_o(act),
    .timeout_flag_o(tmo_f), .powerdown_flag_o(pdn_f), .watchdog_reset_flag_o(wr_f)
  );

  always #(CLK_PERIOD_NS / 2) ref_clk_i = ~ref_clk_i;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // tick phase is unknown to the bench, so counts are judged within a window
  task automatic chk_rng(input logic [31:0] got, input int lo, input int hi);
    if (!$isunknown(got) && got >= lo && got <= hi) chk(got, got);
    else chk(got, 32'(lo));
  endtask

  task automatic axw(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    bit done;
    done = 0;
    r = 2'h3;
    @(posedge ref_clk_i);
    aw_a <= a;
    wd <= d;
    ws <= s;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge ref_clk_i);
      if (aw_v && aw_rdy) aw_v <= 1'b0;
      if (w_v && w_rdy) w_v <= 1'b0;
      if (b_v === 1'b1) begin
        r = bresp;
        b_r <= 1'b0;
        done = 1;
      end
    end
    if (!done) chk(32'h0, 32'h1);
  endtask

  task automatic axr(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    bit done;
    done = 0;
    d = '1;
    r = 2'h3;
    @(posedge ref_clk_i);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge ref_clk_i);
      if (ar_v && ar_rdy) ar_v <= 1'b0;
      if (r_v === 1'b1) begin
        d = rdata;
        r = rresp;
        r_r <= 1'b0;
        done = 1;
      end
    end
    if (!done) chk(32'h0, 32'h1);
  endtask

  task automatic rdc(input int lo, input int hi);
    axr(COUNT_OFFSET, rd, rs);
    chk_rng(rd, lo, hi);
  endtask

  // mode passes two sync flops, so let it settle before judging
  task automatic cfg(input logic [1:0] m, input logic s);
    @(posedge ref_clk_i);
    mode <= m;
    slp <= s;
    repeat (4) @(posedge ref_clk_i);
  endtask

  task automatic tw(input int n);
    repeat (n * lf + 40) @(posedge ref_clk_i);
  endtask

  task automatic tdone(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk_i = 1'b0;
    sys_rst_i = 1'b1;
    {aw_a, ar_a, wd, ws, aw_v, w_v, b_r, ar_v, r_r} = '0;
    {clr, ofail, st_run, slp} = '0;
    mode = MODE_OFF;
    ctrl_m = 32'h16;
    repeat (16) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    axr(CTRL_OFFSET, rd, rs);
    chk(rd, ctrl_m);
    axr(STATUS_OFFSET, rd, rs);
    chk(rd, 32'h0);
    axr(8'h0C, rd, rs);
    chk(rs, RESP_SLVERR);
    chk(rd, 32'h0);
    tdone("reset");
    for (int i = 0; i < 6; i++) begin
      rnd_d = $random(seed);
      rnd_s = 4'((i % 2) ? 4'hF : {$random(seed)} % 16);
      axw(CTRL_OFFSET, rnd_d, rnd_s, rs);
      if (rnd_s[0]) ctrl_m = rnd_d & 32'h3F;
      axr(CTRL_OFFSET, rd, rs);
      chk(rd, ctrl_m);
    end
    axw(COUNT_OFFSET, 32'h0055AA, 4'hF, rs);
    chk(rs, RESP_OKAY);
    axw(8'h10, 32'h1, 4'hF, rs);
    chk(rs, RESP_SLVERR);
    tdone("registers");
    axw(CTRL_OFFSET, 32'h01, 4'hF, rs);
    tw(1);
    rdc(0, 0);
    chk(act, 1'b0);
    cfg(MODE_SOFT, 1'b0);
    tw(1);
    rdc(1, 2);
    chk(act, 1'b1);
    cfg(MODE_SOFT, 1'b1);
    rdc(0, 1);
    chk(act, 1'b1);
    tw(1);
    rdc(1, 2);
    cfg(MODE_SOFT, 1'b0);
    rdc(0, 1);
    tdone("soft mode");
    for (int k = 0; k < 2; k++) begin
      tw(1);
      rdc(1, 2);
      @(posedge ref_clk_i);
      clr <= (k == 0);
      ofail <= (k == 1);
      @(posedge ref_clk_i);
      clr <= 1'b0;
      ofail <= 1'b0;
      rdc(0, 1);
    end
    @(posedge ref_clk_i);
    st_run <= 1'b1;
    tw(1);
    rdc(0, 0);
    @(posedge ref_clk_i);
    st_run <= 1'b0;
    tdone("clearing");
    axw(CTRL_OFFSET, 32'h0, 4'hF, rs);
    tw(1);
    rdc(0, 0);
    cfg(MODE_NO_SLEEP, 1'b0);
    chk(act, 1'b1);
    cfg(MODE_NO_SLEEP, 1'b1);
    tw(1);
    rdc(0, 0);
    chk(act, 1'b0);
    tdone("modes");
    cfg(MODE_ALWAYS, 1'b0);
    axw(CTRL_OFFSET, 32'h26, 4'hF, rs);
    cfg(MODE_ALWAYS, 1'b1);
    cyc = 0;
    rst_seen = 0;
    while (wake !== 1'b1 && cyc < 60000) begin
      @(posedge ref_clk_i);
      cyc++;
      if (wd_rst !== 1'b0) rst_seen = 1;
    end
    chk_rng(cyc, 31 * lf, 32 * lf + 10);
    chk(rst_seen, 0);
    repeat (3) @(posedge ref_clk_i);
    chk({wr_f, pdn_f, tmo_f}, 3'b011);
    axr(STATUS_OFFSET, rd, rs);
    chk(rd, 32'h3);
    axw(STATUS_OFFSET, 32'h7, 4'hF, rs);
    axr(STATUS_OFFSET, rd, rs);
    chk(rd, 32'h0);
    tdone("sleep timeout");
    // awake time-out: the control register reads 0x26 here (period code 0x13), so a reload is visible
    cfg(MODE_ALWAYS, 1'b0);
    cyc = 0;
    rst_seen = 0;
    while (wd_rst !== 1'b1 && cyc < 60000) begin
      @(posedge ref_clk_i);
      cyc++;
      if (wake !== 1'b0) rst_seen = 1;
    end
    chk_rng(cyc, 31 * lf, 32 * lf + 10);
    chk(rst_seen, 0);
    repeat (3) @(posedge ref_clk_i);
    chk({wr_f, pdn_f, tmo_f}, 3'b101);
    axr(CTRL_OFFSET, rd, rs);
    chk(rd, 32'h16);
    tdone("awake timeout");
    complete_run();
  end

  // the planned sequence needs roughly 120k cycles; this leaves a margin
  initial begin
    #3200000;
    fails++;
    complete_run();
  end
endmodule
